// file: logic/lldet_consts.vh
`ifndef LLDET_CONSTS_VH
`define LLDET_CONSTS_VH

// ----------------------------------------
// clock and timer tick
// ----------------------------------------
`define LLDET_CLK_PERIOD_NS 10
`define LLDET_TICK_NS 1000
`define LLDET_TICK_CYC (`LLDET_TICK_NS / `LLDET_CLK_PERIOD_NS)
`define LLDET_TICK_W 16

// ----------------------------------------
// nominal timeouts in microsecond ticks
// ----------------------------------------
`define LLDET_TO_70US 11'h046
`define LLDET_TO_130US 11'h082
`define LLDET_TO_280US 11'h118
`define LLDET_TO_540US 11'h21C
`define LLDET_TO_1075US 11'h433
`define LLDET_TMR_W 11
`define LLDET_WAKE_REC_US 11'h00A

// ----------------------------------------
// setting codes (resistor decode or fixed)
// ----------------------------------------
`define LLDET_SEL_IC_OFF 3'h0
`define LLDET_SEL_70 3'h1
`define LLDET_SEL_130 3'h2
`define LLDET_SEL_280 3'h3
`define LLDET_SEL_540 3'h4
`define LLDET_SEL_1075 3'h5

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define LLDET_ADR_CTRL 4'h0
`define LLDET_ADR_STATUS 4'h4
`define LLDET_ADR_DISCNT 4'h8
`define LLDET_CTRL_RST 6'h00
`define LLDET_CTRL_SRC_BIT 0
`define LLDET_CTRL_FIX_LSB 1
`define LLDET_CTRL_FAST_BIT 4
`define LLDET_CTRL_EXC_BIT 5

`endif

// file: logic/lldet_tick.v
`timescale 1ns/10ps
`default_nettype none
`include "lldet_consts.vh"

// free-running divider standing in for the internal oscillator
module lldet_tick #(
  parameter DIV = 100
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // one-cycle tick
  output reg tick
);

  reg [`LLDET_TICK_W-1:0] cnt_ff; // cycles since last tick

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_ff == DIV[`LLDET_TICK_W-1:0] - 16'h0001) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: logic/lldet_top.v
`timescale 1ns/10ps
`default_nettype none
`include "lldet_consts.vh"

// Operation
// - idle timer counts while sense shows no conduction
// - expiry sets disable flag, low-consumption mode
// - expiry resets timer, halves the timeout
// - disabled: conduction edge starts timed wake
// - idle wake shares trigger_disable_input exit path
// - conduction end starts the idle timer
// - gap under quarter: reset timer only
// - gap quarter-to-half restores full timeout
// - timeout 70/130/280/540/1075 us selectable
// - low resistor disables device; high disables detection
// - pulse outside disable conducted without delay
// - sequencer restarts on supply-good or disable
// - fast-slope and exception options mutually exclusive
// - negative-sense comparator report drives the timer
// - timeout from resistor or fixed production selection
module lldet_top #(
  parameter TICK_CYC = `LLDET_TICK_CYC,
  parameter WAKE_TICKS = `LLDET_WAKE_REC_US
) (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [3:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  // sense, supply and pins
  input wire CS_NEG,
  input wire TRIG_DISABLE_IN,
  input wire VCC_OK,
  input wire [2:0] RSEL_CODE,
  // controller outputs
  output reg DISABLE_FLAG,
  output reg WAKING,
  output reg DRV_ALLOW,
  output reg SEQ_START,
  output reg FAST_SLOPE_EN,
  output reg EXC_TIMER_EN
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  // binary codes; the state number is readable in the status word
  localparam [2:0] ST_START = 3'h0; // sequencer start
  localparam [2:0] ST_ACTIVE = 3'h1; // normal conduction
  localparam [2:0] ST_DISABLED = 3'h2; // low consumption
  localparam [2:0] ST_WAKE = 3'h3; // recovery in progress
  localparam [2:0] ST_IC_OFF = 3'h4; // held off by resistor

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire tick; // one microsecond tick
  wire bus_req; // wishbone request pending
  wire bus_wr; // write strobe on request
  reg [5:0] ctrl_ff; // control register
  reg [2:0] state_ff; // sequencer state
  reg [2:0] nxt_state;
  reg [10:0] tmr_ff; // idle timer in ticks
  reg [10:0] nxt_tmr;
  reg half_ff; // timeout halved
  reg nxt_half;
  reg [10:0] wake_ff; // wake recovery count
  reg [10:0] nxt_wake;
  reg cs_neg_d_ff; // previous sense sample
  reg vcc_d_ff; // previous supply-good sample
  reg [15:0] discnt_ff; // idle disable entries
  // combinational decode results
  reg [2:0] sel; // effective setting code
  reg [10:0] nominal; // full timeout in ticks
  reg [10:0] limit; // active timeout
  reg [10:0] quarter; // quarter of nominal
  reg [10:0] half; // half of nominal
  reg detect_on; // detection enabled
  // edge and compare terms
  wire cond_start; // sense went negative
  wire vcc_rise; // supply became good
  wire idle_exp; // timer reached limit

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  // the tick stands in for the internal oscillator; a shorter
  // divider shrinks every timeout alike, which keeps tests short
  lldet_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk(CLOCK),
    .rst(RESET),
    .tick(tick)
  );

  // ----------------------------------------
  // setting decode
  // ----------------------------------------
  // codes 6 and 7 (high or floating resistor) switch detection off;
  // code 0 (low resistor) is caught by the sequencer override;
  // thresholds are plain shifts, so they round down
  // fixed selection overrides the resistor when chosen
  always @* begin
    if (ctrl_ff[`LLDET_CTRL_SRC_BIT]) begin
      sel = ctrl_ff[`LLDET_CTRL_FIX_LSB+2:`LLDET_CTRL_FIX_LSB];
    end else begin
      sel = RSEL_CODE;
    end
    detect_on = 1'b1;
    case (sel)
      `LLDET_SEL_70: nominal = `LLDET_TO_70US;
      `LLDET_SEL_130: nominal = `LLDET_TO_130US;
      `LLDET_SEL_280: nominal = `LLDET_TO_280US;
      `LLDET_SEL_540: nominal = `LLDET_TO_540US;
      `LLDET_SEL_1075: nominal = `LLDET_TO_1075US;
      default: begin
        nominal = `LLDET_TO_1075US;
        detect_on = 1'b0;
      end
    endcase
    quarter = {2'b00, nominal[10:2]};
    half = {1'b0, nominal[10:1]};
    limit = half_ff ? half : nominal;
  end

  // edges of the comparator report and supply level
  assign cond_start = CS_NEG & ~cs_neg_d_ff;
  assign vcc_rise = VCC_OK & ~vcc_d_ff;
  // expiry only while the sense is positive, so a conduction edge
  // in the same cycle always wins over expiry
  assign idle_exp = detect_on & ~CS_NEG & (tmr_ff >= limit);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // one next-state process; the override chain at the bottom
  // takes priority over the per-state decisions
  always @* begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_half = half_ff;
    nxt_wake = wake_ff;
    case (state_ff)
      ST_START: begin
        // start state resolves at once to active unless an override below applies
        nxt_tmr = 11'h000;
        nxt_state = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (cond_start) begin
          // gap length decides the timeout for the next round
          nxt_tmr = 11'h000;
          if (tmr_ff >= quarter && tmr_ff < half) begin
            nxt_half = 1'b0;
          end
        end else if (idle_exp) begin
          nxt_tmr = 11'h000;
          nxt_half = 1'b1;
          nxt_state = ST_DISABLED;
        end else if (~CS_NEG & tick & detect_on) begin
          nxt_tmr = tmr_ff + 11'h001;
        end
      end
      ST_DISABLED: begin
        // a new conduction edge while the pin is released begins the wake
        if (cond_start & ~TRIG_DISABLE_IN) begin
          nxt_wake = 11'h000;
          nxt_state = ST_WAKE;
        end
      end
      // recovery counted in ticks; its length is a parameter
      ST_WAKE: begin
        if (tick) begin
          nxt_wake = wake_ff + 11'h001;
        end
        if (wake_ff >= WAKE_TICKS[10:0]) begin
          nxt_tmr = 11'h000;
          nxt_state = ST_ACTIVE;
        end
      end
      ST_IC_OFF: begin
        // left only through the override chain
        nxt_state = ST_IC_OFF;
      end
      default: nxt_state = ST_START;
    endcase
    // overriding conditions, in priority order
    if (!VCC_OK || sel == `LLDET_SEL_IC_OFF) begin
      // supply loss or low resistor holds the whole device off
      nxt_state = ST_IC_OFF;
    end else if (state_ff == ST_IC_OFF || vcc_rise) begin
      // leaving hold-off or supply return restarts the sequencer
      nxt_state = ST_START;
    end else if (TRIG_DISABLE_IN && state_ff != ST_DISABLED) begin
      // pin disable from any running state
      nxt_state = ST_DISABLED;
    end else if (state_ff == ST_DISABLED && !TRIG_DISABLE_IN && !detect_on) begin
      // with detection off there is no conduction edge to wait for
      nxt_state = ST_WAKE;
      nxt_wake = 11'h000;
    end
  end

  // ----------------------------------------
  // state registers and outputs
  // ----------------------------------------
  // outputs are registered from the next state so they align with it
  always @(posedge CLOCK) begin
    if (RESET) begin
      // held off with the flag raised until supply and setting are seen
      state_ff <= ST_IC_OFF;
      tmr_ff <= 11'h000;
      half_ff <= 1'b0;
      wake_ff <= 11'h000;
      cs_neg_d_ff <= 1'b0;
      vcc_d_ff <= 1'b0;
      discnt_ff <= 16'h0000;
      DISABLE_FLAG <= 1'b1;
      WAKING <= 1'b0;
      DRV_ALLOW <= 1'b0;
      SEQ_START <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      half_ff <= nxt_half;
      wake_ff <= nxt_wake;
      cs_neg_d_ff <= CS_NEG;
      vcc_d_ff <= VCC_OK;
      // counts idle expiries only, not pin disables;
      // a limitation: the counter wraps after 65535 entries
      if (state_ff == ST_ACTIVE && nxt_state == ST_DISABLED && idle_exp) begin
        discnt_ff <= discnt_ff + 16'h0001;
      end
      DISABLE_FLAG <= (nxt_state == ST_DISABLED) || (nxt_state == ST_IC_OFF);
      WAKING <= (nxt_state == ST_WAKE);
      // no wake delay when the pulse meets an active controller
      DRV_ALLOW <= (nxt_state == ST_ACTIVE) || (nxt_state == ST_START);
      // pulse whenever the sequencer is sent back to start
      SEQ_START <= (nxt_state == ST_START) ||
                   (nxt_state == ST_DISABLED && state_ff != ST_DISABLED);
    end
  end

  // ----------------------------------------
  // option outputs
  // ----------------------------------------
  // the two options must never drive at once, so one is masked
  // exception timer wins if software asks for both
  always @(posedge CLOCK) begin
    if (RESET) begin
      FAST_SLOPE_EN <= 1'b0;
      EXC_TIMER_EN <= 1'b0;
    end else begin
      EXC_TIMER_EN <= ctrl_ff[`LLDET_CTRL_EXC_BIT];
      FAST_SLOPE_EN <= ctrl_ff[`LLDET_CTRL_FAST_BIT] & ~ctrl_ff[`LLDET_CTRL_EXC_BIT];
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign bus_req = CYC_I & STB_I & ~ACK_O;
  assign bus_wr = bus_req & WE_I;

  // reads have no side effects; unmapped offsets answer with zero
  // a write with byte lane 0 off is acknowledged but dropped
  // data is zero outside the answer cycle so a shared bus can or it
  // one wait state: ack one edge after the request is seen
  always @(posedge CLOCK) begin
    if (RESET) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
      ctrl_ff <= `LLDET_CTRL_RST;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= 32'h00000000;
      if (bus_wr && ADR_I == `LLDET_ADR_CTRL && SEL_I[0]) begin
        ctrl_ff <= DAT_I[5:0];
      end
      if (bus_req && !WE_I) begin
        if (ADR_I == `LLDET_ADR_CTRL) begin
          DAT_O <= {26'h0000000, ctrl_ff};
        end else if (ADR_I == `LLDET_ADR_STATUS) begin
          DAT_O <= {5'h00, tmr_ff, 8'h00, detect_on, half_ff, sel, state_ff};
        end else if (ADR_I == `LLDET_ADR_DISCNT) begin
          DAT_O <= {16'h0000, discnt_ff};
        end else begin
          DAT_O <= 32'h00000000; // unmapped reads zero
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/lldet_sense_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// sense comparator stand-in
// ----
module lldet_sense_model (
  // clock
  input wire logic clk,
  // bench command
  input wire logic go,
  input wire logic [7:0] len,
  // comparator report, high while conducting
  output logic cs_neg
);
  logic [7:0] left_ff = 8'h00; // conduction cycles still to run
  // a burst of len cycles; between bursts the sense sits positive
  always_ff @(posedge clk) begin
    if (go) left_ff <= len;
    else if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
  end
  assign cs_neg = (left_ff != 8'h00);
endmodule
`default_nettype wire

// file: tb/lldet_props.sv
`timescale 1ns/10ps
`default_nettype none
module lldet_props #(
  parameter TICK_CYC = 100,
  parameter WAKE_TICKS = 10
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // sense, supply and pins
  input wire logic CS_NEG,
  input wire logic TRIG_DISABLE_IN,
  input wire logic VCC_OK,
  input wire logic [2:0] RSEL_CODE,
  // outputs
  input wire logic DISABLE_FLAG,
  input wire logic WAKING,
  input wire logic DRV_ALLOW,
  input wire logic SEQ_START,
  input wire logic FAST_SLOPE_EN,
  input wire logic EXC_TIMER_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_ack_taken: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  a_ack_none: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("stray ack");
  a_dat_quiet: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data not zero");
  a_opts_excl: assert property (!(FAST_SLOPE_EN && EXC_TIMER_EN))
    else $error("both options on");
  a_off_holds: assert property (RSEL_CODE == 3'h0 ##1 RSEL_CODE == 3'h0 |->
    DISABLE_FLAG && !DRV_ALLOW) else $error("ic off not disabled");
  a_dis_nodrv: assert property (DISABLE_FLAG |-> !DRV_ALLOW)
    else $error("drive while disabled");
  a_wake_entry: assert property ($rose(WAKING) |-> $past(DISABLE_FLAG))
    else $error("wake without disable");
  a_wake_done: assert property ($fell(WAKING) && !DISABLE_FLAG |-> DRV_ALLOW)
    else $error("wake end without drive");
  a_seq_on_dis: assert property ($rose(DISABLE_FLAG) && RSEL_CODE != 3'h0 && VCC_OK |->
    SEQ_START || $past(SEQ_START)) else $error("no restart on disable");
  a_seq_on_vcc: assert property ($rose(VCC_OK) && RSEL_CODE != 3'h0 |=> SEQ_START)
    else $error("no restart on supply");
  a_no_delay: assert property ($rose(CS_NEG) && DRV_ALLOW && !TRIG_DISABLE_IN |=>
    !WAKING) else $error("delay outside disable");
endmodule
bind lldet_top lldet_props #(.TICK_CYC(TICK_CYC), .WAKE_TICKS(WAKE_TICKS)) u_props (
  .CLOCK(CLOCK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .CS_NEG(CS_NEG), .TRIG_DISABLE_IN(TRIG_DISABLE_IN), .VCC_OK(VCC_OK), .RSEL_CODE(RSEL_CODE),
  .DISABLE_FLAG(DISABLE_FLAG), .WAKING(WAKING), .DRV_ALLOW(DRV_ALLOW), .SEQ_START(SEQ_START),
  .FAST_SLOPE_EN(FAST_SLOPE_EN), .EXC_TIMER_EN(EXC_TIMER_EN));
`default_nettype wire

// file: tb/tb_light_load_idle_detector.sv
`timescale 1ns/10ps
`default_nettype none
`include "lldet_consts.vh"
module tb_light_load_idle_detector;
  // ----
  // bench signals
  // ----
  logic clock = 0, reset = 1, cyc = 0, stb = 0, we = 0, trig = 0, go = 0, vcc = 1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat_i = 32'h0, rd;
  logic [7:0] len = 8'h00;
  logic [2:0] rsel = `LLDET_SEL_70;
  wire [31:0] dat_o;
  wire ack, cs_neg, dis, waking, drv, seq, fast, exc;
  int n_mismatch = 0, num_checks = 0;
  initial forever #5 clock = ~clock;
  // tick of 2 cycles keeps a 70 tick timeout at 140 cycles
  lldet_top #(.TICK_CYC(2), .WAKE_TICKS(3)) u_dut (.CLOCK(clock), .RESET(reset), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
    .CS_NEG(cs_neg), .TRIG_DISABLE_IN(trig), .VCC_OK(vcc), .RSEL_CODE(rsel),
    .DISABLE_FLAG(dis), .WAKING(waking), .DRV_ALLOW(drv), .SEQ_START(seq),
    .FAST_SLOPE_EN(fast), .EXC_TIMER_EN(exc));
  lldet_sense_model u_sense (.clk(clock), .go(go), .len(len), .cs_neg(cs_neg));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one classic cycle; the ack wait is bounded
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat_i <= d;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (ack !== 1'b1 && i < 9);
    if (ack !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clock);
  endtask
  task automatic rd_st;
    wb(0, `LLDET_ADR_STATUS, 32'h0);
  endtask
  // conduction burst of n cycles from the partner
  task automatic start(input logic [7:0] n);
    go <= 1;
    len <= n;
    @(posedge clock);
    go <= 0;
  endtask
  task automatic until_flag(input logic v, input int n);
    int i;
    i = 0;
    while (dis !== v && i < n) begin
      @(posedge clock);
      i++;
    end
    chk("disable_flag", 32'(dis), 32'(v));
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    idle(20);
    reset <= 0;
    idle(2);
    chk("seq_start", 32'(seq), 32'h1);
    idle(2);
    chk("drv_allow", 32'({drv, dis}), 32'h2);
    wb(0, `LLDET_ADR_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    wb(1, 4'hC, 32'h5A);
    wb(0, 4'hC, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1, `LLDET_ADR_CTRL, 32'h30);
    idle(2);
    chk("fast_exc", 32'({fast, exc}), 32'h1);
    wb(1, `LLDET_ADR_CTRL, 32'h10);
    idle(2);
    chk("fast_exc", 32'({fast, exc}), 32'h2);
    wb(1, `LLDET_ADR_CTRL, 32'h05);
    rd_st();
    chk("fixed_code", 32'(rd[5:3]), 32'h2);
    wb(1, `LLDET_ADR_CTRL, 32'h0);
    start(2);
    for (int c = 1; c <= 5; c++) begin
      rsel <= 3'(c);
      idle(2);
      rd_st();
      chk("code", 32'(rd[7:3]), 32'(c) | 32'h10);
    end
    rsel <= `LLDET_SEL_70;
    // full timeout of 140 cycles from the end of a burst
    start(4);
    idle(128);
    chk("early", 32'(dis), 32'h0);
    until_flag(1, 40);
    rd_st();
    chk("half", 32'({rd[26:16], rd[6], rd[2:0]}), 32'h00A);
    wb(0, `LLDET_ADR_DISCNT, 32'h0);
    chk("discnt", rd, 32'h1);
    start(30);
    idle(3);
    chk("waking", 32'(waking), 32'h1);
    idle(30);
    chk("awake", 32'({drv, dis}), 32'h2);
    idle(6);
    start(4);
    idle(2);
    chk("no_delay", 32'({drv, waking}), 32'h2);
    idle(4);
    rd_st();
    chk("short_gap", 32'(rd[6]), 32'h1);
    idle(45);
    start(4);
    idle(10);
    rd_st();
    chk("mid_gap", 32'(rd[6]), 32'h0);
    idle(110);
    chk("full_again", 32'(dis), 32'h0);
    until_flag(1, 40);
    // trigger input holds the disable
    trig <= 1;
    start(4);
    idle(8);
    chk("trig_hold", 32'(waking), 32'h0);
    trig <= 0;
    idle(2);
    start(4);
    idle(2);
    chk("trig_wake", 32'(waking), 32'h1);
    idle(20);
    trig <= 1;
    until_flag(1, 10);
    chk("seq_start", 32'(seq), 32'h1);
    trig <= 0;
    rsel <= `LLDET_SEL_IC_OFF;
    idle(4);
    chk("ic_off", 32'({drv, dis}), 32'h1);
    rsel <= 3'h6;
    idle(4);
    start(4);
    idle(300);
    chk("detect_off", 32'(dis), 32'h0);
    // detection off: pin release alone starts the wake
    trig <= 1;
    idle(3);
    trig <= 0;
    idle(3);
    chk("off_wake", 32'(waking), 32'h1);
    // supply loss holds off, supply return restarts the sequencer
    vcc <= 0;
    idle(3);
    chk("vcc_low", 32'({drv, dis}), 32'h1);
    vcc <= 1;
    idle(2);
    chk("vcc_rise", 32'({seq, drv, dis}), 32'h6);
    wrap_up();
  end
endmodule
`default_nettype wire
